// File: pkg/nprd_defines.svh
// Register offsets, field positions, reset values, commands and timing counts
`ifndef NPRD_DEFINES_SVH
`define NPRD_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define NPRD_OFS_CTRL         8'h00
`define NPRD_OFS_COL          8'h04
`define NPRD_OFS_ROW          8'h08
`define NPRD_OFS_STATUS       8'h0C
`define NPRD_OFS_DATA         8'h10
`define NPRD_OFS_ID_LO        8'h14
`define NPRD_OFS_ID_HI        8'h18

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define NPRD_CTRL_START       0
`define NPRD_CTRL_OP_LSB      1
`define NPRD_CTRL_OP_MSB      3
`define NPRD_CTRL_SKIP_SETUP  4
`define NPRD_CTRL_CE_RELEASE  5

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define NPRD_ST_BUSY          0
`define NPRD_ST_DONE          1
`define NPRD_ST_READY         2
`define NPRD_ST_TIMEOUT       3
`define NPRD_ST_COL_LSB       16
`define NPRD_ST_COL_MSB       27

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define NPRD_RST_COL          12'h000
`define NPRD_RST_ROW          16'h0000
`define NPRD_RST_WORD         32'h0000_0000
`define NPRD_RST_BYTE         8'h00

// ------------------------------------------------------------
// Device commands and page geometry
// ------------------------------------------------------------
`define NPRD_CMD_READ_SETUP   8'h00
`define NPRD_CMD_READ_CONFIRM 8'h30
`define NPRD_CMD_READ_ID      8'h90
`define NPRD_CMD_RAND_OUT     8'h05
`define NPRD_CMD_RAND_CONFIRM 8'hE0
`define NPRD_CMD_RESET        8'hFF
`define NPRD_ID_ADDR          8'h00
`define NPRD_LAST_COL         12'h83F
`define NPRD_ID_LAST          3'h4

// ------------------------------------------------------------
// Timing: figures in ns or us, then cycle counts at the clock rate
// ------------------------------------------------------------
`define NPRD_CLK_NS           10
`define NPRD_TSETUP_NS        12
`define NPRD_TWP_NS           12
`define NPRD_TWH_NS           10
`define NPRD_TWB_NS           100
`define NPRD_TWHR_NS          60
`define NPRD_TREA_NS          20
`define NPRD_TREH_NS          10
`define NPRD_TR_US            25
`define NPRD_TRST_US          5
`define NPRD_SETUP_CYC  ((`NPRD_TSETUP_NS + `NPRD_CLK_NS - 1) / `NPRD_CLK_NS)
`define NPRD_TWP_CYC    ((`NPRD_TWP_NS + `NPRD_CLK_NS - 1) / `NPRD_CLK_NS)
`define NPRD_TWH_CYC    ((`NPRD_TWH_NS + `NPRD_CLK_NS - 1) / `NPRD_CLK_NS)
`define NPRD_TWB_CYC    ((`NPRD_TWB_NS + `NPRD_CLK_NS - 1) / `NPRD_CLK_NS)
`define NPRD_TWHR_CYC   ((`NPRD_TWHR_NS + `NPRD_CLK_NS - 1) / `NPRD_CLK_NS)
`define NPRD_TREA_CYC   ((`NPRD_TREA_NS + `NPRD_CLK_NS - 1) / `NPRD_CLK_NS)
`define NPRD_TREH_CYC   ((`NPRD_TREH_NS + `NPRD_CLK_NS - 1) / `NPRD_CLK_NS)
`define NPRD_TR_CYC     ((`NPRD_TR_US * 1000) / `NPRD_CLK_NS)
`define NPRD_TRST_CYC   ((`NPRD_TRST_US * 1000) / `NPRD_CLK_NS)

`endif

// File: pkg/nprd_pkg.sv
// Types shared by the page read and ID host controller
package nprd_pkg;

    // Sequencer states
    typedef enum logic [3:0] {
        NPRD_ST_IDLE  = 4'b0000,
        NPRD_ST_CMD1  = 4'b0001,
        NPRD_ST_ADDR  = 4'b0010,
        NPRD_ST_CMD2  = 4'b0011,
        NPRD_ST_WB    = 4'b0100,
        NPRD_ST_RDY   = 4'b0101,
        NPRD_ST_WHR   = 4'b0110,
        NPRD_ST_READ  = 4'b0111,
        NPRD_ST_FIN   = 4'b1000
    } nprd_state_t;

    // Operations that software may start
    typedef enum logic [2:0] {
        NPRD_OP_PAGE  = 3'b000,
        NPRD_OP_ID    = 3'b001,
        NPRD_OP_RCOL  = 3'b010,
        NPRD_OP_BYTE  = 3'b011,
        NPRD_OP_RESET = 3'b100
    } nprd_op_t;

endpackage

// File: src/nprd_host.sv
// Host controller issuing page read, random column, read ID and reset to a NAND device
//
// Function
// - Host programs block pages in ascending order
// - Chip select may drop between sequential reads
// - Four address bytes: column low, high, row
// - ID command returns five bytes in order
// - Page read: setup, four addresses, confirm (the setup command is left out when skip_setup is set)
// - Wait for ready after confirm before reading
// - Each read strobe gives next column byte
// - Random output command selects new column
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "nprd_defines.svh"

module nprd_host (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             nand_ce_n,
    output logic             nand_cle,
    output logic             nand_ale,
    output logic             nand_we_n,
    output logic             read_strobe_n,
    output logic      [7:0]  nand_io_out,
    output logic             nand_io_oe,
    input  wire logic [7:0]  nand_io_in,
    input  wire logic        nand_ready
);

    // ------------------------------------------------------------
    // Constants sized for the counters
    // ------------------------------------------------------------
    localparam logic [11:0] WR_SETUP = 12'(`NPRD_SETUP_CYC);                    // Strobe setup
    localparam logic [11:0] WR_LOW   = 12'(`NPRD_SETUP_CYC + `NPRD_TWP_CYC);    // End of low
    localparam logic [11:0] WR_LAST  = 12'(`NPRD_SETUP_CYC + `NPRD_TWP_CYC + `NPRD_TWH_CYC - 1);
    localparam logic [11:0] RD_LOW   = 12'(`NPRD_TREA_CYC);                     // Sample point
    localparam logic [11:0] RD_LAST  = 12'(`NPRD_TREA_CYC + `NPRD_TREH_CYC - 1);
    localparam logic [11:0] WB_LAST  = 12'(`NPRD_TWB_CYC - 1);
    localparam logic [11:0] WHR_LAST = 12'(`NPRD_TWHR_CYC - 1);
    localparam logic [11:0] TR_MAX   = 12'(`NPRD_TR_CYC);                       // Load bound
    localparam logic [11:0] TRST_MAX = 12'(`NPRD_TRST_CYC);                     // Reset bound

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    nprd_pkg::nprd_state_t state;          // Sequencer state
    nprd_pkg::nprd_op_t    op;             // Operation in flight
    logic [11:0]           cnt;            // Cycle counter inside a state
    logic [2:0]            acnt;           // Address byte index
    logic [2:0]            bcnt;           // ID byte index
    logic [11:0]           col;            // Column for page read or random output
    logic [15:0]           row;            // Row address
    logic [11:0]           col_ptr;        // Mirror of device output column
    logic                  skip_setup;     // Omit the read setup command
    logic                  ce_release;     // Drop chip select while idle
    logic                  done;           // Sticky completion flag
    logic                  timeout;        // Sticky busy timeout flag
    logic [7:0]            rd_data;        // Last single byte read
    logic [7:0]            id_mem [0:4];   // Captured ID bytes
    logic                  wr_pend;        // Write data phase pending
    logic [7:0]            wr_ofs;         // Offset of pending write
    logic                  go;             // Start request from software
    logic                  fin;            // Operation completes this cycle
    logic [7:0]            wbyte;          // Byte driven in write states
    logic                  wr_state;       // In a write strobe state
    logic [2:0]            addr_last;      // Last address index of the op

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Address byte by index: column low, column high, row low, row high
    function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [11:0] c,
                                             input logic [15:0] r);
        case (idx)
            3'h0:    addr_byte = c[7:0];
            3'h1:    addr_byte = {4'h0, c[11:8]};
            3'h2:    addr_byte = r[7:0];
            default: addr_byte = r[15:8];
        endcase
    endfunction

    // Column mirror advance, stopping at the last column
    function automatic logic [11:0] col_next(input logic [11:0] c);
        col_next = (c == `NPRD_LAST_COL) ? c : c + 12'h001;
    endfunction

    // ------------------------------------------------------------
    // Decode of the current write byte
    // ------------------------------------------------------------
    always_comb
    begin
        wr_state  = (state == nprd_pkg::NPRD_ST_CMD1) || (state == nprd_pkg::NPRD_ST_ADDR)
                 || (state == nprd_pkg::NPRD_ST_CMD2);
        addr_last = (op == nprd_pkg::NPRD_OP_ID) ? 3'h0
                  : (op == nprd_pkg::NPRD_OP_RCOL) ? 3'h1 : 3'h3;
        wbyte     = `NPRD_RST_BYTE;
        case (state)
            nprd_pkg::NPRD_ST_CMD1:
            begin
                // First command of the operation
                // Only read-type commands and reset exist, so page order cannot break
                case (op)
                    nprd_pkg::NPRD_OP_ID:    wbyte = `NPRD_CMD_READ_ID;
                    nprd_pkg::NPRD_OP_RCOL:  wbyte = `NPRD_CMD_RAND_OUT;
                    nprd_pkg::NPRD_OP_RESET: wbyte = `NPRD_CMD_RESET;
                    default:                 wbyte = `NPRD_CMD_READ_SETUP;
                endcase
            end
            nprd_pkg::NPRD_ST_ADDR:
            begin
                // ID takes a single zero address; random output the column only; page read the column and row
                wbyte = (op == nprd_pkg::NPRD_OP_ID) ? `NPRD_ID_ADDR : addr_byte(acnt, col, row);
            end
            nprd_pkg::NPRD_ST_CMD2:
            begin
                // Confirm command
                wbyte = (op == nprd_pkg::NPRD_OP_RCOL) ? `NPRD_CMD_RAND_CONFIRM
                                                       : `NPRD_CMD_READ_CONFIRM;
            end
            default:
            begin
                wbyte = `NPRD_RST_BYTE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Bus slave: address capture, read data, writes
    // ------------------------------------------------------------
    assign go  = wr_pend && (wr_ofs == `NPRD_OFS_CTRL) && hwdata[`NPRD_CTRL_START]
              && (state == nprd_pkg::NPRD_ST_IDLE);
    assign fin = (state == nprd_pkg::NPRD_ST_FIN);

    // Address phase capture and zero wait answer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend   <= 1'b0;
            wr_ofs    <= 8'h00;
            hrdata    <= `NPRD_RST_WORD;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= hready && hsel && htrans[1] && hwrite;
            wr_ofs    <= haddr[7:0];
            if (hready && hsel && htrans[1] && !hwrite)
            begin
                // Unmapped offsets read as zero
                case (haddr[7:0])
                    `NPRD_OFS_CTRL:   hrdata <= {26'h0, ce_release, skip_setup, op, 1'b0};
                    `NPRD_OFS_COL:    hrdata <= {20'h0, col};
                    `NPRD_OFS_ROW:    hrdata <= {16'h0, row};
                    `NPRD_OFS_STATUS: hrdata <= {4'h0, col_ptr, 12'h0, timeout, nand_ready,
                                                 done, (state != nprd_pkg::NPRD_ST_IDLE)};
                    `NPRD_OFS_DATA:   hrdata <= {24'h0, rd_data};
                    `NPRD_OFS_ID_LO:  hrdata <= {id_mem[3], id_mem[2], id_mem[1], id_mem[0]};
                    `NPRD_OFS_ID_HI:  hrdata <= {24'h0, id_mem[4]};
                    default:          hrdata <= `NPRD_RST_WORD;
                endcase
            end
        end
    end

    // Software writable settings; ignored while an operation runs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            col        <= `NPRD_RST_COL;
            row        <= `NPRD_RST_ROW;
            op         <= nprd_pkg::NPRD_OP_PAGE;
            skip_setup <= 1'b0;
            ce_release <= 1'b0;
        end
        else if (wr_pend && (state == nprd_pkg::NPRD_ST_IDLE))
        begin
            case (wr_ofs)
                `NPRD_OFS_CTRL:
                begin
                    op         <= nprd_pkg::nprd_op_t'(hwdata[`NPRD_CTRL_OP_MSB:`NPRD_CTRL_OP_LSB]);
                    skip_setup <= hwdata[`NPRD_CTRL_SKIP_SETUP];
                    ce_release <= hwdata[`NPRD_CTRL_CE_RELEASE];
                end
                `NPRD_OFS_COL: col <= hwdata[11:0];
                `NPRD_OFS_ROW: row <= hwdata[15:0];
                default:       col <= col;
            endcase
        end
    end

    // Sticky flags: hardware set wins over write-one clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            done    <= 1'b0;
            timeout <= 1'b0;
        end
        else
        begin
            if (fin)
                done <= 1'b1;
            else if (wr_pend && (wr_ofs == `NPRD_OFS_STATUS) && hwdata[`NPRD_ST_DONE])
                done <= 1'b0;
            if ((state == nprd_pkg::NPRD_ST_RDY) && !nand_ready
                && (cnt == ((op == nprd_pkg::NPRD_OP_RESET) ? TRST_MAX : TR_MAX)))
                timeout <= 1'b1;
            else if (wr_pend && (wr_ofs == `NPRD_OFS_STATUS) && hwdata[`NPRD_ST_TIMEOUT])
                timeout <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer and device pins
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state         <= nprd_pkg::NPRD_ST_IDLE;
            cnt           <= 12'h000;
            acnt          <= 3'h0;
            bcnt          <= 3'h0;
            nand_ce_n     <= 1'b1;
            nand_cle      <= 1'b0;
            nand_ale      <= 1'b0;
            nand_we_n     <= 1'b1;
            read_strobe_n <= 1'b1;
            nand_io_out   <= `NPRD_RST_BYTE;
            nand_io_oe    <= 1'b0;
        end
        else
        begin
            // Write strobe shape: setup, low pulse, high hold
            nand_io_out   <= wbyte;
            nand_io_oe    <= wr_state;
            nand_cle      <= (state == nprd_pkg::NPRD_ST_CMD1) || (state == nprd_pkg::NPRD_ST_CMD2);
            nand_ale      <= (state == nprd_pkg::NPRD_ST_ADDR);
            nand_we_n     <= !(wr_state && (cnt >= WR_SETUP) && (cnt < WR_LOW));
            read_strobe_n <= !((state == nprd_pkg::NPRD_ST_READ) && (cnt < RD_LOW));
            cnt           <= cnt + 12'h001;
            case (state)
                nprd_pkg::NPRD_ST_IDLE:
                begin
                    cnt <= 12'h000;
                    if (go)
                    begin
                        nand_ce_n <= 1'b0;
                        acnt      <= 3'h0;
                        bcnt      <= 3'h0;
                        if (op == nprd_pkg::NPRD_OP_BYTE)
                            state <= nprd_pkg::NPRD_ST_RDY;
                        else if ((op == nprd_pkg::NPRD_OP_PAGE) && skip_setup)
                            state <= nprd_pkg::NPRD_ST_ADDR;
                        else
                            state <= nprd_pkg::NPRD_ST_CMD1;
                    end
                    else if (ce_release)
                        nand_ce_n <= 1'b1;
                end
                nprd_pkg::NPRD_ST_CMD1:
                begin
                    if (cnt == WR_LAST)
                    begin
                        cnt   <= 12'h000;
                        state <= (op == nprd_pkg::NPRD_OP_RESET) ? nprd_pkg::NPRD_ST_WB
                                                                 : nprd_pkg::NPRD_ST_ADDR;
                    end
                end
                nprd_pkg::NPRD_ST_ADDR:
                begin
                    if (cnt == WR_LAST)
                    begin
                        cnt  <= 12'h000;
                        acnt <= acnt + 3'h1;
                        if (acnt == addr_last)
                            state <= (op == nprd_pkg::NPRD_OP_ID) ? nprd_pkg::NPRD_ST_WHR
                                                                  : nprd_pkg::NPRD_ST_CMD2;
                    end
                end
                nprd_pkg::NPRD_ST_CMD2:
                begin
                    if (cnt == WR_LAST)
                    begin
                        cnt   <= 12'h000;
                        state <= (op == nprd_pkg::NPRD_OP_PAGE) ? nprd_pkg::NPRD_ST_WB
                                                                : nprd_pkg::NPRD_ST_WHR;
                    end
                end
                nprd_pkg::NPRD_ST_WB:
                begin
                    // Let the device pull ready low before looking at it
                    if (cnt == WB_LAST)
                    begin
                        cnt   <= 12'h000;
                        state <= nprd_pkg::NPRD_ST_RDY;
                    end
                end
                nprd_pkg::NPRD_ST_RDY:
                begin
                    // No read strobe until the device is ready
                    if (nand_ready)
                    begin
                        cnt   <= 12'h000;
                        state <= (op == nprd_pkg::NPRD_OP_BYTE) ? nprd_pkg::NPRD_ST_READ
                                                                : nprd_pkg::NPRD_ST_FIN;
                    end
                    else if (cnt == ((op == nprd_pkg::NPRD_OP_RESET) ? TRST_MAX : TR_MAX))
                        state <= nprd_pkg::NPRD_ST_FIN;
                end
                nprd_pkg::NPRD_ST_WHR:
                begin
                    if (cnt == WHR_LAST)
                    begin
                        cnt   <= 12'h000;
                        state <= (op == nprd_pkg::NPRD_OP_ID) ? nprd_pkg::NPRD_ST_READ
                                                              : nprd_pkg::NPRD_ST_FIN;
                    end
                end
                nprd_pkg::NPRD_ST_READ:
                begin
                    if (cnt == RD_LAST)
                    begin
                        cnt  <= 12'h000;
                        bcnt <= bcnt + 3'h1;
                        if ((op != nprd_pkg::NPRD_OP_ID) || (bcnt == `NPRD_ID_LAST))
                            state <= nprd_pkg::NPRD_ST_FIN;
                    end
                end
                nprd_pkg::NPRD_ST_FIN:
                begin
                    cnt   <= 12'h000;
                    state <= nprd_pkg::NPRD_ST_IDLE;
                end
                default:
                begin
                    state <= nprd_pkg::NPRD_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Captured data and column mirror
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_data <= `NPRD_RST_BYTE;
            col_ptr <= `NPRD_RST_COL;
            for (int i = 0; i < 5; i++)
                id_mem[i] <= `NPRD_RST_BYTE;
        end
        else
        begin
            if (go && ((op == nprd_pkg::NPRD_OP_PAGE) || (op == nprd_pkg::NPRD_OP_RCOL)))
                col_ptr <= col;
            if ((state == nprd_pkg::NPRD_ST_READ) && (cnt == RD_LOW))
            begin
                if (op == nprd_pkg::NPRD_OP_ID)
                    id_mem[bcnt] <= nand_io_in;
                else
                begin
                    rd_data <= nand_io_in;
                    col_ptr <= col_next(col_ptr);
                end
            end
        end
    end

endmodule

// File: tb/nprd_host_properties.sv
// Checker of bus answer and strobe timing at the host ports
`timescale 1ns/1ps
module nprd_host_properties (
    input wire logic hclk, hresetn, hreadyout, hresp, nand_ce_n, nand_cle,
    input wire logic nand_ale, nand_we_n, read_strobe_n, nand_io_oe, nand_ready,
    input wire logic [7:0] nand_io_out
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (!hresp && hreadyout)
        else $error("bus answer not okay");
    a_we_pulse: assert property ($fell(nand_we_n) |=> !nand_we_n ##1 nand_we_n)
        else $error("write strobe width");
    a_re_pulse: assert property ($fell(read_strobe_n) |=> !read_strobe_n ##1 read_strobe_n)
        else $error("read strobe width");
    a_re_ready: assert property ($fell(read_strobe_n) |-> nand_ready && !nand_ce_n)
        else $error("read strobe while busy");
    a_strobe_excl: assert property (!(nand_cle && nand_ale) && (nand_we_n || read_strobe_n))
        else $error("latch or strobe clash");
    a_we_latch: assert property (!nand_we_n |-> nand_io_oe && !nand_ce_n && (nand_cle || nand_ale))
        else $error("write strobe unqualified");
    a_we_stable: assert property (!nand_we_n |-> $stable(nand_io_out) && $stable(nand_cle))
        else $error("byte moved under strobe");
    a_re_release: assert property (!read_strobe_n |-> !nand_io_oe && !nand_cle && !nand_ale)
        else $error("host drives during read");
endmodule
bind nprd_host nprd_host_properties chk (.*);

// File: tb/nprd_nand_model.sv
// Behavioural NAND device for page read, random column, ID and reset
`timescale 1ns/1ps
module nprd_nand_model #(
    parameter logic [39:0] ID       = 40'h0,
    parameter int          LOAD_CYC = 300
) (
    input wire logic hclk, ce_n, cle, ale, we_n, re_n,
    input wire logic [7:0] din,
    output logic [7:0] dout,
    output logic ready
);
    logic [7:0]  adr [4];        // Address bytes of the current group
    logic [7:0]  q   = 8'h00;    // Byte shown while read strobe is low
    logic [1:0]  na  = 2'h0;
    logic [11:0] col = 12'h000;  // Kept while chip select is high
    logic [15:0] row = 16'h0000;
    int          idp = -1;       // ID pointer, negative outside ID mode
    initial ready = 1'b1;        // Setup counts as latched
    task automatic hold_busy(input int n);
        ready = 1'b0;
        repeat (n) @(posedge hclk);
        ready = 1'b1;
    endtask
    // Latch addresses and commands on write strobe rise
    always @(posedge we_n)
        if (!ce_n && ale)
        begin
            adr[na] = din;
            na++;
        end
        else if (!ce_n && cle)
        begin
            idp = (din == 8'h90) ? 0 : -1;
            if (din == 8'h30 || din == 8'hE0) col = {adr[1][3:0], adr[0]};
            if (din == 8'h30) row = {adr[3], adr[2]};
            na = 2'h0;
            if (din == 8'h30) hold_busy(LOAD_CYC);
            if (din == 8'hFF) hold_busy(LOAD_CYC / 3);
        end
    // Next byte on each read strobe fall
    always @(negedge re_n)
        if (!ce_n && ready)
        begin
            q = (idp >= 0) ? ID[8*idp +: 8] : row[7:0] ^ col[7:0] ^ {4'h0, col[11:8]};
            if (idp >= 0) idp = (idp + 1) % 5;
            else if (col < 12'h83F) col++;
        end
    assign dout = (!re_n && !ce_n) ? q : ~q; // Released bus shows the inverse
endmodule

// File: tb/tb.sv
// Self-checking bench of the page read and ID host controller
`timescale 1ns/1ps
module tb;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, nand_ce_n, nand_cle, nand_ale, nand_we_n, read_strobe_n;
    logic nand_io_oe, nand_ready;
    logic [7:0] nand_io_out, nand_io_in;
    logic [31:0] seed = 32'h0001_2CF5;
    logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
    int error_cnt = 0, compares = 0;
    wire hready = hreadyout;
    // Two low bytes arbitrary; then fifth, fourth, third from fields
    localparam logic [39:0] ID = {{1'b0, 3'b011, 2'b01, 2'b00},
        {2'b00, 2'b01, 1'b0, 1'b1, 2'b01}, {1'b1, 1'b0, 2'b01, 4'h0}, 16'h3CA5};
    always #5 hclk = ~hclk;
    nprd_host uut (.*);
    nprd_nand_model #(.ID(ID)) dev (.hclk, .ce_n(nand_ce_n), .cle(nand_cle),
        .ale(nand_ale), .we_n(nand_we_n), .re_n(read_strobe_n), .din(nand_io_out),
        .dout(nand_io_in), .ready(nand_ready));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One edge, then more while the slave stalls
    task automatic edge_rdy;
        @(posedge hclk);
        for (int n = 0; hreadyout !== 1'b1; n++)
        begin
            if (n == 50) begin error_cnt++; close_out; end
            @(posedge hclk);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
        edge_rdy;
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        edge_rdy;
        q = hrdata;
    endtask
    // Start one operation and poll until done
    task automatic run(input logic [2:0] op, input logic skip, input logic cer);
        int n;
        ahb(1, 8'h0C, 32'h0000_000A);
        ahb(1, 8'h00, {26'h0, cer, skip, op, 1'b0});
        ahb(1, 8'h00, {26'h0, cer, skip, op, 1'b1});
        // Stale read data must not end the poll before one status read
        q = 32'h0000_0000;
        for (n = 0; n < 2000 && q[1] !== 1'b1; n++) ahb(0, 8'h0C, 0);
        chk("done", {q[3], q[1]}, 2'b01);
        if (n == 2000) close_out;
    endtask
    task automatic byte_chk(input logic [15:0] r, input logic [11:0] c, input logic cer);
        run(3'h3, 1'b0, cer);
        chk("col mirror", {20'h0, q[27:16]}, (c == 12'h83F) ? c : c + 12'h001);
        ahb(0, 8'h10, 0);
        chk("page byte", q, {24'h0, r[7:0] ^ c[7:0] ^ {4'h0, c[11:8]}});
    endtask
    initial
    begin
        logic [15:0] row;
        int col;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1, 8'h1C, 32'hFFFF_FFFF);
        foreach (ofs[i]) begin ahb(0, ofs[i], 0); chk("reset", q, i == 3 ? 4 : 0); end
        for (int k = 0; k < 3; k++)
        begin
            row = rnd();
            col = (k == 2) ? 2110 : rnd() % 2100;
            ahb(1, 8'h04, col);
            ahb(1, 8'h08, row);
            run(3'h0, k == 0, k == 2);
            for (int b = 0; b < 2; b++) byte_chk(row, col + b, k == 2);
            for (int j = 0; j < 2; j++)
            begin
                col = rnd() % 2112;
                ahb(1, 8'h04, col);
                run(3'h2, 1'b0, 1'b0);
                byte_chk(row, col, 1'b0);
            end
        end
        run(3'h1, 1'b0, 1'b0);
        ahb(0, 8'h14, 0);
        chk("id low", q, ID[31:0]);
        ahb(0, 8'h18, 0);
        chk("id high", q, {24'h0, ID[39:32]});
        run(3'h4, 1'b0, 1'b0);
        close_out;
    end
endmodule
